// file: hdl/isr_map.vh
/*
  register offsets, field positions and reset values of the interrupt
  status readback block; assumes an apb slave with byte addresses.
*/
`ifndef ISR_MAP_VH
`define ISR_MAP_VH
`define ISR_OFS_LIVE1 8'h23
`define ISR_OFS_LTCH0 8'h24
`define ISR_OFS_LTCH1 8'h25
`define ISR_OFS_LTCH2 8'h26
`define ISR_OFS_MASK0 8'h20
`define ISR_OFS_MASK1 8'h21
`define ISR_OFS_LIVE0 8'h22
`define ISR_OFS_CFG 8'h30
`define ISR_LIVE1_USED 8'h8f
`define ISR_LTCH1_USED 8'h8f
`define ISR_LTCH2_RST 8'h02
`define ISR_MASK0_RST 8'hfc
`define ISR_MASK1_RST 8'hb1
`define ISR_CFG_RST 2'h1
`define ISR_MODE_LIVE 2'h0
`define ISR_MODE_LTCH 2'h1
`define ISR_MODE_ONCE 2'h2
`define ISR_MODE_REPEAT 2'h3
`define ISR_PULSE_NS 2000000
`define ISR_PERIOD_NS 4000000
`define ISR_CLK_NS 10
`endif

// file: hdl/isr_latch.v
/*
  one latched status byte: sets on event, clears on read.
  assumes clr is a one-cycle pulse from the bus slave.
*/
`default_nettype none
module isr_latch #(
  parameter WIDTH = 8,
  parameter [7:0] RST_VAL = 8'h00,
  parameter [7:0] USED = 8'hff
) (
  input wire pclk,
  input wire presetn,
  input wire [WIDTH-1:0] evt,
  input wire clr,
  output wire [WIDTH-1:0] q
);
  reg [WIDTH-1:0] bits_ff;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          bits_ff[i] <= RST_VAL[i];
        end else if (!USED[i]) begin
          bits_ff[i] <= 1'b0;
        end else begin
          bits_ff[i] <= evt[i] | (bits_ff[i] & ~clr);
        end
      end
    end
  endgenerate
  assign q = bits_ff;
endmodule
`default_nettype wire

// file: hdl/isr_top.v
/*
  interrupt status readback: live and latched status registers, masks,
  pin mode and the interrupt pin driver behind an apb slave.
  assumes event inputs are synchronous to pclk.
*/
// Decided for this implementation: the APB interface to the registers.
`include "isr_map.vh"
`default_nettype none
module isr_top #(
  parameter PULSE_CYC = `ISR_PULSE_NS / `ISR_CLK_NS,
  parameter PERIOD_CYC = `ISR_PERIOD_NS / `ISR_CLK_NS
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] live0_evt,
  input wire pdm_data_invalid,
  input wire overvoltage_lockout,
  input wire undervoltage_lockout,
  input wire brown_out,
  input wire pdm_clk_err,
  input wire [7:0] ltch2_evt,
  output reg irq_output_pin
);
  reg [7:0] live0_ff;
  reg [7:0] live1_ff;
  reg [7:0] mask0_ff;
  reg [7:0] mask1_ff;
  reg [1:0] irq_pin_mode_cfg_ff;
  reg [15:0] prev_live_ff;
  reg [21:0] cnt_ff;
  reg pulse_ff;
  wire [2:0] rd_clr;
  wire [7:0] ltch0_q;
  wire [7:0] ltch1_q;
  wire [7:0] ltch2_q;
  wire [7:0] nxt_live1;
  wire [7:0] word_ofs;
  wire in_range;
  wire acc_rd;
  wire acc_wr;
  reg [7:0] rd_byte;
  reg rd_err;
  wire [7:0] act0;
  wire [7:0] act1;
  wire [7:0] act2;
  wire any_live;
  wire any_ltch;
  wire live_rise;
  reg nxt_pin;

  // live snapshot of second group
  assign nxt_live1 = {pdm_data_invalid, 3'b000,
                      overvoltage_lockout, undervoltage_lockout,
                      brown_out, pdm_clk_err};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live0_ff <= 8'h00;
      live1_ff <= 8'h00;
    end else begin
      live0_ff <= live0_evt;
      live1_ff <= nxt_live1;
    end
  end

  assign word_ofs = paddr[9:2];
  assign in_range = (paddr[31:10] == 22'h000000) && (paddr[1:0] == 2'b00);
  assign acc_rd = psel && penable && !pwrite;
  assign acc_wr = psel && penable && pwrite;

  // clear at the edge that captures read data, so no later event is lost
  assign rd_clr[0] = acc_rd && !pready && in_range && word_ofs == `ISR_OFS_LTCH0;
  assign rd_clr[1] = acc_rd && !pready && in_range && word_ofs == `ISR_OFS_LTCH1;
  assign rd_clr[2] = acc_rd && !pready && in_range && word_ofs == `ISR_OFS_LTCH2;

  // events come from the live snapshot for groups 0 and 1
  isr_latch #(.WIDTH(8), .RST_VAL(8'h00), .USED(8'hff)) u_ltch0 (
    .pclk(pclk),
    .presetn(presetn),
    .evt(live0_ff),
    .clr(rd_clr[0]),
    .q(ltch0_q)
  );
  isr_latch #(.WIDTH(8), .RST_VAL(8'h00), .USED(`ISR_LTCH1_USED)) u_ltch1 (
    .pclk(pclk),
    .presetn(presetn),
    .evt(live1_ff),
    .clr(rd_clr[1]),
    .q(ltch1_q)
  );
  isr_latch #(.WIDTH(8), .RST_VAL(`ISR_LTCH2_RST), .USED(8'hff)) u_ltch2 (
    .pclk(pclk),
    .presetn(presetn),
    .evt(ltch2_evt),
    .clr(rd_clr[2]),
    .q(ltch2_q)
  );

  // read mux
  always @* begin
    rd_byte = 8'h00;
    rd_err = 1'b0;
    if (!in_range) begin
      rd_err = 1'b1;
    end else begin
      case (word_ofs)
        `ISR_OFS_MASK0: rd_byte = mask0_ff;
        `ISR_OFS_MASK1: rd_byte = mask1_ff;
        `ISR_OFS_LIVE0: rd_byte = live0_ff;
        `ISR_OFS_LIVE1: rd_byte = live1_ff & `ISR_LIVE1_USED;
        `ISR_OFS_LTCH0: rd_byte = ltch0_q;
        `ISR_OFS_LTCH1: rd_byte = ltch1_q & `ISR_LTCH1_USED;
        `ISR_OFS_LTCH2: rd_byte = ltch2_q;
        `ISR_OFS_CFG: rd_byte = {6'b000000, irq_pin_mode_cfg_ff};
        default: rd_err = 1'b1;
      endcase
    end
  end

  // apb slave, one wait state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      mask0_ff <= `ISR_MASK0_RST;
      mask1_ff <= `ISR_MASK1_RST;
      irq_pin_mode_cfg_ff <= `ISR_CFG_RST;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        if (pwrite) begin
          pslverr <= !in_range || !(word_ofs == `ISR_OFS_MASK0 || word_ofs == `ISR_OFS_MASK1 ||
                     word_ofs == `ISR_OFS_CFG);
        end else begin
          prdata <= {24'h000000, rd_byte};
          pslverr <= rd_err;
        end
      end
      if (acc_wr && pready && in_range && pstrb[0]) begin
        if (word_ofs == `ISR_OFS_MASK0) begin
          mask0_ff <= pwdata[7:0];
        end
        if (word_ofs == `ISR_OFS_MASK1) begin
          mask1_ff <= pwdata[7:0];
        end
        if (word_ofs == `ISR_OFS_CFG) begin
          irq_pin_mode_cfg_ff <= pwdata[1:0];
        end
      end
    end
  end

  // unmasked sources
  assign act0 = live0_ff & ~mask0_ff;
  assign act1 = live1_ff & ~mask1_ff & `ISR_LIVE1_USED;
  assign any_live = |act0 || |act1;
  assign any_ltch = |(ltch0_q & ~mask0_ff) || |(ltch1_q & ~mask1_ff & `ISR_LTCH1_USED) || |ltch2_q;
  // rising unmasked live bit, each group against its own history
  assign live_rise = |(live0_ff & ~prev_live_ff[7:0] & ~mask0_ff) ||
                     |(live1_ff & ~prev_live_ff[15:8] & ~mask1_ff & `ISR_LIVE1_USED);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_live_ff <= 16'h0000;
      cnt_ff <= 22'h000000;
      pulse_ff <= 1'b0;
    end else begin
      prev_live_ff <= {live1_ff & `ISR_LIVE1_USED, live0_ff};
      case (irq_pin_mode_cfg_ff)
        `ISR_MODE_ONCE: begin
          if (live_rise && !pulse_ff) begin
            pulse_ff <= 1'b1;
            cnt_ff <= 22'h000000;
          end else if (pulse_ff) begin
            if (cnt_ff == PULSE_CYC - 1) begin
              pulse_ff <= 1'b0;
            end
            cnt_ff <= cnt_ff + 22'h000001;
          end
        end
        `ISR_MODE_REPEAT: begin
          if (any_ltch || cnt_ff != 22'h000000) begin
            cnt_ff <= (cnt_ff == PERIOD_CYC - 1) ? 22'h000000 : cnt_ff + 22'h000001;
          end
          pulse_ff <= (cnt_ff < PULSE_CYC) && (any_ltch || cnt_ff != 22'h000000);
        end
        default: begin
          cnt_ff <= 22'h000000;
          pulse_ff <= 1'b0;
        end
      endcase
    end
  end

  always @* begin
    case (irq_pin_mode_cfg_ff)
      `ISR_MODE_LIVE: nxt_pin = any_live;
      `ISR_MODE_LTCH: nxt_pin = any_ltch;
      default: nxt_pin = pulse_ff;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_output_pin <= 1'b0;
    end else begin
      irq_output_pin <= nxt_pin;
    end
  end
endmodule
`default_nettype wire

// file: bench/isr_top_asserts.sv
/*
  apb timing and status readback checks on the isr_top ports.
  assumes one pclk domain, presetn async active low.
*/
`default_nettype none
module isr_top_asserts(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pdm_data_invalid,
  input wire logic overvoltage_lockout,
  input wire logic undervoltage_lockout,
  input wire logic brown_out,
  input wire logic pdm_clk_err
);
  logic [4:0] lv;
  logic [4:0] lv1_ff, lv2_ff, lv3_ff;
  assign lv = {pdm_data_invalid, overvoltage_lockout, undervoltage_lockout, brown_out, pdm_clk_err};
  always @(posedge pclk) begin
    lv1_ff <= lv;
    lv2_ff <= lv1_ff;
    lv3_ff <= lv2_ff;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rd(logic [31:0] a);
    psel && penable && pready && !pwrite && paddr == a;
  endsequence
  a_ready_one_wait: assert property ($rose(psel && penable) |=> pready) else $error("late or missing pready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
  a_ready_only_req: assert property (pready |-> psel && penable) else $error("pready without request");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  a_live_rsvd: assert property (s_rd(32'h8c) |-> prdata[6:4] == 3'h0) else $error("live reserved set");
  a_ltch1_rsvd: assert property (s_rd(32'h94) |-> prdata[6:4] == 3'h0) else $error("latched reserved set");
  a_live_value: assert property (s_rd(32'h8c) ##0 (lv1_ff == lv && lv2_ff == lv && lv3_ff == lv)
    |-> prdata[7:0] == {lv[4], 3'h0, lv[3:0]}) else $error("live value wrong");
  a_ro_refused: assert property (pready && pwrite && paddr == 32'h8c |-> pslverr) else $error("write accepted");
  a_unmapped_err: assert property (pready && paddr[31:8] != 24'h0 |-> pslverr) else $error("unmapped accepted");
endmodule
bind isr_top isr_top_asserts isr_top_asserts_i(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pdm_data_invalid(pdm_data_invalid), .overvoltage_lockout(overvoltage_lockout),
  .undervoltage_lockout(undervoltage_lockout), .brown_out(brown_out), .pdm_clk_err(pdm_clk_err));
`default_nettype wire

// file: bench/tb_top.sv
/*
  apb testbench for isr_top: reset values, live, latched, refusals, pin modes.
  assumes short pulse counts 20/40 and one wait state per access.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_output_pin;
  logic [31:0] paddr, pwdata, prdata;
  logic [7:0] live0_evt, ltch2_evt;
  logic [4:0] lv;
  int failures, n_checks, cyc;
  isr_top #(.PULSE_CYC(20), .PERIOD_CYC(40)) isr_top_i(.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .live0_evt(live0_evt), .pdm_data_invalid(lv[4]),
    .overvoltage_lockout(lv[3]), .undervoltage_lockout(lv[2]), .brown_out(lv[1]), .pdm_clk_err(lv[0]),
    .ltch2_evt(ltch2_evt), .irq_output_pin(irq_output_pin));
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, x);
    n_checks++;
    if (g !== x) begin
      failures++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task xfer(input logic w, input logic [31:0] a, d, e, input logic err);
    int k;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    psel <= 0;
    penable <= 0;
    if (!w) chk(prdata, e);
    chk({31'h0, pslverr}, {31'h0, err});
  endtask
  task rd(input logic [31:0] a, e);
    xfer(1'b0, a, 32'h0, e, 1'b0);
  endtask
  task pin(input logic v, input int n);
    int k;
    for (k = 0; k < n && irq_output_pin !== v; k++) @(posedge pclk);
    chk({31'h0, irq_output_pin}, {31'h0, v});
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, live0_evt, ltch2_evt, lv} = '0;
    {failures, n_checks, cyc} = '0;
    presetn = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1;
    rd(32'h98, 32'h02);
    rd(32'h98, 32'h00);
    rd(32'h90, 32'h00);
    rd(32'h94, 32'h00);
    lv <= 5'b11001;
    repeat (3) @(posedge pclk);
    rd(32'h8c, 32'h89);
    rd(32'h8c, 32'h89);
    lv <= 5'b00110;
    repeat (3) @(posedge pclk);
    rd(32'h8c, 32'h06);
    lv <= 5'b0;
    repeat (3) @(posedge pclk);
    rd(32'h94, 32'h8f);
    rd(32'h94, 32'h00);
    $display("live tests done");
    live0_evt <= 8'hff;
    ltch2_evt <= 8'hff;
    @(posedge pclk);
    live0_evt <= 8'h0;
    ltch2_evt <= 8'h0;
    repeat (3) @(posedge pclk);
    rd(32'h90, 32'hff);
    rd(32'h90, 32'h00);
    rd(32'h98, 32'hff);
    rd(32'h98, 32'h00);
    $display("latched tests done");
    ltch2_evt <= 8'h10;
    repeat (3) @(posedge pclk);
    rd(32'h98, 32'h10);
    rd(32'h98, 32'h10);
    ltch2_evt <= 8'h0;
    rd(32'h98, 32'h10);
    xfer(1'b1, 32'h8c, 32'hff, 32'h0, 1'b1);
    xfer(1'b0, 32'h200, 32'h0, 32'h0, 1'b1);
    $display("refusal tests done");
    live0_evt <= 8'h01;
    @(posedge pclk);
    live0_evt <= 8'h0;
    pin(1'b1, 5);
    rd(32'h90, 32'h01);
    pin(1'b0, 5);
    xfer(1'b1, 32'hc0, 32'h0, 32'h0, 1'b0);
    live0_evt <= 8'h02;
    pin(1'b1, 5);
    live0_evt <= 8'h0;
    pin(1'b0, 5);
    xfer(1'b1, 32'hc0, 32'h2, 32'h0, 1'b0);
    live0_evt <= 8'h01;
    pin(1'b1, 5);
    pin(1'b0, 25);
    repeat (60) @(posedge pclk);
    chk({31'h0, irq_output_pin}, 32'h0);
    xfer(1'b1, 32'hc0, 32'h3, 32'h0, 1'b0);
    pin(1'b1, 45);
    pin(1'b0, 25);
    pin(1'b1, 45);
    $display("pin mode tests done");
    stop_test();
  end
endmodule
`default_nettype wire
